// [rsc_defs.svh]
// Constants of the reset source controller: offsets, bit positions, timing
// Functional notes
// RULE1 - Monitor control bit 7 switches supply monitor
// RULE2 - Monitor resets only when selected as source
// RULE3 - Software lets monitor settle before selecting
// RULE4 - Monitor control bit 6 shows live supply
// RULE5 - Monitor control bits 5..0 reserved, writes ignored
// RULE6 - Low reset pin requests a device reset
// RULE7 - Cause bit 0 flags pin reset
// RULE8 - Stalled clock beyond timeout triggers reset
// RULE9 - Cause bit 2 flags/enables clock loss
// RULE10 - Pin left undriven for internal resets
// RULE11 - Cause bit 5 enables comparator reset
// RULE12 - Cause bit 5 reads comparator reset flag
// RULE13 - Software settles comparator before selecting it
// RULE14 - Watchdog enabled, clock/12 after any reset
// RULE15 - Cause bit 3 flags watchdog reset
// RULE16 - Flash write above code limit resets
// RULE17 - Code read or fetch above limit resets
// RULE18 - Forbidden flash access by security resets
// RULE19 - Cause bit 6 read-only flash fault flag
// RULE20 - Cause bit 4 write forces reset, flags it
// RULE21 - Cause bit 1 power flag, selects monitor
// RULE22 - Cause bit 7 reads zero, ignores writes
// RULE23 - Read-modify-write sees stored enables, not flags
// RULE24 - Other resets clear power-up flag
// RULE25 - Only power-on disables supply monitor
// RULE26 - Drive pin low for power/supply resets
// RULE27 - Only responsible source flag reads one
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_ADDR_CAUSE      8'hef
`define RSC_ADDR_SUPPLY     8'hff

`define RSC_BIT_PIN         0
`define RSC_BIT_POWER       1
`define RSC_BIT_CLK_LOSS    2
`define RSC_BIT_WATCHDOG    3
`define RSC_BIT_SOFT        4
`define RSC_BIT_COMPARATOR  5
`define RSC_BIT_FLASH       6
`define RSC_BIT_MON_ON      7
`define RSC_BIT_SUPPLY_OK   6

`define RSC_LIMIT_16K       16'h3dff
`define RSC_LIMIT_8K        16'h1fff

`define RSC_CLK_PERIOD_NS   10
`define RSC_CLK_LOSS_US     100
`define RSC_CLK_LOSS_CYC    ((`RSC_CLK_LOSS_US * 1000) / `RSC_CLK_PERIOD_NS)
`define RSC_RST_DELAY_NS    5000
`define RSC_RST_DELAY_CYC   ((`RSC_RST_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV         12

`endif

// [rsc_pkg.sv]
// Types shared by the reset source controller
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_ST_POWER = 2'b00,
        RSC_ST_RUN   = 2'b01,
        RSC_ST_HOLD  = 2'b10
    } rsc_state_e;

    typedef logic [6:0] rsc_cause_t;
    typedef logic [7:0] rsc_byte_t;
endpackage

// [rsc_clk_loss.sv]
// Clock loss one-shot: times out when clock activity ticks stop arriving
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_clk_loss #(
    parameter int unsigned TIMEOUT_CYC = `RSC_CLK_LOSS_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic alive_tick,
    output logic      expired_q
);
    import rsc_pkg::*;

    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        expired_d;

    // Each activity tick retriggers the one-shot
    always_comb begin
        count_d   = count_q;
        expired_d = 1'b0;
        if (!enable || alive_tick) begin
            count_d = 16'h0000;
        end else if (count_q >= 16'(TIMEOUT_CYC - 1)) begin
            expired_d = 1'b1; // RULE8
        end else begin
            count_d = count_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q   <= 16'h0000;
            expired_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            expired_q <= expired_d;
        end
    end
endmodule

// [rsc_reset_source_controller.sv]
// Reset source controller: collects reset sources, records cause, sequences reset
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_source_controller #(
    parameter int unsigned CLK_LOSS_CYC = `RSC_CLK_LOSS_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    input  wire logic [7:0]  sfr_wdata,
    output rsc_pkg::rsc_byte_t sfr_rdata_q,
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe,
    input  wire logic        supply_above_threshold,
    input  wire logic        clk_alive_tick,
    input  wire logic        comparator_out,
    input  wire logic        watchdog_timeout,
    input  wire logic        watchdog_disable,
    input  wire logic        part_16k,
    input  wire logic        program_store_write_enable,
    input  wire logic        flash_wr_strobe,
    input  wire logic [15:0] flash_wr_addr,
    input  wire logic        code_rd_strobe,
    input  wire logic [15:0] code_rd_addr,
    input  wire logic        fetch_strobe,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        flash_sec_violation,
    output logic             sys_reset_q,
    output logic             supply_monitor_on_q,
    output logic             watchdog_enable_q,
    output logic             watchdog_tick_q
);
    import rsc_pkg::*;

    localparam int unsigned DELAY_CYC = `RSC_RST_DELAY_CYC;

    rsc_state_e  state_q;
    rsc_state_e  state_d;
    rsc_cause_t  cause_q;
    rsc_cause_t  cause_d;
    rsc_cause_t  req;
    logic [9:0]  delay_q;
    logic [9:0]  delay_d;
    logic        mon_on_d;
    logic        supply_sel_q;
    logic        supply_sel_d;
    logic        comp_en_q;
    logic        comp_en_d;
    logic        loss_en_q;
    logic        loss_en_d;
    logic        sys_reset_d;
    logic        pin_oe_d;
    logic        wdt_en_d;
    logic [3:0]  wdt_div_q;
    logic [3:0]  wdt_div_d;
    logic        wdt_tick_d;
    rsc_byte_t   rdata_d;
    logic [15:0] limit;
    logic        loss_expired;
    logic        wr_cause;
    logic        wr_supply;
    logic        hold_pin;
    logic        hold_supply;

    assign limit     = part_16k ? `RSC_LIMIT_16K : `RSC_LIMIT_8K;
    assign wr_cause  = sfr_wr && (sfr_addr == `RSC_ADDR_CAUSE) && (state_q == RSC_ST_RUN);
    assign wr_supply = sfr_wr && (sfr_addr == `RSC_ADDR_SUPPLY) && (state_q == RSC_ST_RUN);

    rsc_clk_loss #(
        .TIMEOUT_CYC (CLK_LOSS_CYC)
    ) u_clk_loss (
        .clk        (clk),
        .rstn       (rstn),
        .enable     (loss_en_q && (state_q == RSC_ST_RUN)),
        .alive_tick (clk_alive_tick),
        .expired_q  (loss_expired)
    );

    // Source requests, one bit per cause position
    always_comb begin
        req = '0;
        req[`RSC_BIT_PIN]        = !rst_pin_i; // RULE6
        req[`RSC_BIT_POWER]      = supply_monitor_on_q && supply_sel_q
                                   && !supply_above_threshold; // RULE2
        req[`RSC_BIT_CLK_LOSS]   = loss_expired; // RULE8
        req[`RSC_BIT_WATCHDOG]   = watchdog_enable_q && watchdog_timeout;
        req[`RSC_BIT_SOFT]       = wr_cause && sfr_wdata[`RSC_BIT_SOFT]; // RULE20
        req[`RSC_BIT_COMPARATOR] = comp_en_q && !comparator_out; // RULE11
        req[`RSC_BIT_FLASH]      = (program_store_write_enable && flash_wr_strobe
                                    && (flash_wr_addr > limit)) // RULE16
                                   || (code_rd_strobe && (code_rd_addr > limit)) // RULE17
                                   || (fetch_strobe && (fetch_addr > limit)) // RULE17
                                   || flash_sec_violation; // RULE18
    end

    // Conditions that stretch the hold until the source goes away
    // Own drive masks the pin, else a supply hold would hold itself forever;
    // an outside pull during such a hold goes unseen
    assign hold_pin    = !rst_pin_i && !rst_pin_oe;
    assign hold_supply = cause_q[`RSC_BIT_POWER] && !supply_above_threshold;

    // Sequencer and cause capture
    always_comb begin
        state_d      = state_q;
        cause_d      = cause_q;
        delay_d      = delay_q;
        mon_on_d     = supply_monitor_on_q;
        supply_sel_d = supply_sel_q;
        comp_en_d    = comp_en_q;
        loss_en_d    = loss_en_q;
        sys_reset_d  = sys_reset_q;
        pin_oe_d     = 1'b0;
        wdt_en_d     = watchdog_enable_q;
        case (state_q)
            RSC_ST_POWER: begin
                sys_reset_d = 1'b1;
                pin_oe_d    = 1'b1; // RULE26
                if (!supply_above_threshold) begin
                    delay_d = 10'h000;
                end else if (delay_q < 10'(DELAY_CYC - 1)) begin
                    delay_d = delay_q + 10'h001;
                end else begin
                    state_d     = RSC_ST_RUN;
                    sys_reset_d = 1'b0;
                    pin_oe_d    = 1'b0;
                    wdt_en_d    = 1'b1; // RULE14
                end
            end
            RSC_ST_RUN: begin
                if (wr_supply) begin
                    mon_on_d = sfr_wdata[`RSC_BIT_MON_ON]; // RULE1 RULE5
                end
                if (wr_cause) begin
                    supply_sel_d = sfr_wdata[`RSC_BIT_POWER]; // RULE21
                    loss_en_d    = sfr_wdata[`RSC_BIT_CLK_LOSS]; // RULE9
                    comp_en_d    = sfr_wdata[`RSC_BIT_COMPARATOR]; // RULE11
                end
                if (watchdog_disable) begin
                    wdt_en_d = 1'b0;
                end
                if (req != '0) begin
                    // Fixed priority so one flag alone reads one
                    cause_d = '0; // RULE24 RULE27
                    if (req[`RSC_BIT_POWER]) begin
                        cause_d[`RSC_BIT_POWER] = 1'b1;
                    end else if (req[`RSC_BIT_PIN]) begin
                        cause_d[`RSC_BIT_PIN] = 1'b1; // RULE7
                    end else if (req[`RSC_BIT_CLK_LOSS]) begin
                        cause_d[`RSC_BIT_CLK_LOSS] = 1'b1; // RULE9
                    end else if (req[`RSC_BIT_COMPARATOR]) begin
                        cause_d[`RSC_BIT_COMPARATOR] = 1'b1; // RULE12
                    end else if (req[`RSC_BIT_WATCHDOG]) begin
                        cause_d[`RSC_BIT_WATCHDOG] = 1'b1; // RULE15
                    end else if (req[`RSC_BIT_FLASH]) begin
                        cause_d[`RSC_BIT_FLASH] = 1'b1; // RULE19
                    end else begin
                        cause_d[`RSC_BIT_SOFT] = 1'b1; // RULE20
                    end
                    // Source enables drop so a stale selection cannot loop the reset
                    supply_sel_d = 1'b0;
                    comp_en_d    = 1'b0;
                    loss_en_d    = 1'b0;
                    delay_d      = 10'h000;
                    sys_reset_d  = 1'b1;
                    pin_oe_d     = req[`RSC_BIT_POWER]; // RULE10 RULE26
                    state_d      = RSC_ST_HOLD;
                end
            end
            RSC_ST_HOLD: begin
                sys_reset_d = 1'b1;
                pin_oe_d    = cause_q[`RSC_BIT_POWER]; // RULE10 RULE26
                if (hold_pin || hold_supply) begin
                    delay_d = 10'h000;
                end else if (delay_q < 10'(DELAY_CYC - 1)) begin
                    delay_d = delay_q + 10'h001;
                end else begin
                    state_d     = RSC_ST_RUN;
                    sys_reset_d = 1'b0;
                    pin_oe_d    = 1'b0;
                    wdt_en_d    = 1'b1; // RULE14
                end
            end
            default: begin
                state_d = RSC_ST_POWER;
            end
        endcase
    end

    // Watchdog time base runs at the system clock divided by twelve
    always_comb begin
        wdt_div_d  = wdt_div_q;
        wdt_tick_d = 1'b0;
        if (sys_reset_q || !watchdog_enable_q) begin
            wdt_div_d = 4'h0;
        end else if (wdt_div_q == 4'(`RSC_WDT_DIV - 1)) begin
            wdt_div_d  = 4'h0;
            wdt_tick_d = 1'b1; // RULE14
        end else begin
            wdt_div_d = wdt_div_q + 4'h1;
        end
    end

    // Register reads; a read-modify-write sees the stored enables
    always_comb begin
        rdata_d = sfr_rdata_q;
        if (sfr_rd) begin
            if (sfr_addr == `RSC_ADDR_CAUSE) begin
                rdata_d = {1'b0, cause_q}; // RULE22 RULE19
                if (sfr_rmw) begin
                    rdata_d[`RSC_BIT_COMPARATOR] = comp_en_q; // RULE23
                    rdata_d[`RSC_BIT_SOFT]       = 1'b0; // RULE23
                    rdata_d[`RSC_BIT_CLK_LOSS]   = loss_en_q; // RULE23
                    rdata_d[`RSC_BIT_POWER]      = supply_sel_q; // RULE23
                end
            end else if (sfr_addr == `RSC_ADDR_SUPPLY) begin
                rdata_d = 8'h00; // RULE5
                rdata_d[`RSC_BIT_MON_ON]    = supply_monitor_on_q; // RULE1
                rdata_d[`RSC_BIT_SUPPLY_OK] = supply_above_threshold; // RULE4
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Power-on entry: power flag set, monitor off, pin driven low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q             <= RSC_ST_POWER;
            cause_q             <= 7'h02; // RULE21
            delay_q             <= 10'h000;
            supply_monitor_on_q <= 1'b0; // RULE25
            supply_sel_q        <= 1'b0;
            comp_en_q           <= 1'b0;
            loss_en_q           <= 1'b0;
            sys_reset_q         <= 1'b1;
            rst_pin_oe          <= 1'b1;
            rst_pin_o           <= 1'b0;
            watchdog_enable_q   <= 1'b0;
            wdt_div_q           <= 4'h0;
            watchdog_tick_q     <= 1'b0;
            sfr_rdata_q         <= 8'h00;
        end else begin
            state_q             <= state_d;
            cause_q             <= cause_d;
            delay_q             <= delay_d;
            supply_monitor_on_q <= mon_on_d;
            supply_sel_q        <= supply_sel_d;
            comp_en_q           <= comp_en_d;
            loss_en_q           <= loss_en_d;
            sys_reset_q         <= sys_reset_d;
            rst_pin_oe          <= pin_oe_d;
            rst_pin_o           <= 1'b0;
            watchdog_enable_q   <= wdt_en_d;
            wdt_div_q           <= wdt_div_d;
            watchdog_tick_q     <= wdt_tick_d;
            sfr_rdata_q         <= rdata_d;
        end
    end
endmodule

// [rsc_monitor.sv]
// Port checker of the reset source controller
`timescale 1ns/1ps
module rsc_monitor (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic [7:0]         sfr_addr,
    input wire logic               sfr_wr,
    input wire logic               sfr_rd,
    input wire logic [7:0]         sfr_wdata,
    input wire rsc_pkg::rsc_byte_t sfr_rdata_q,
    input wire logic               rst_pin_i,
    input wire logic               rst_pin_o,
    input wire logic               rst_pin_oe,
    input wire logic               supply_above_threshold,
    input wire logic               sys_reset_q,
    input wire logic               supply_monitor_on_q,
    input wire logic               watchdog_enable_q,
    input wire logic               watchdog_tick_q
);
    import rsc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    pin_drive_a: assert property (rst_pin_oe |-> sys_reset_q && !rst_pin_o)
        else $error("reset pin driven outside reset");
    pin_request_a: assert property (!rst_pin_i && !sys_reset_q |=> sys_reset_q)
        else $error("pin request ignored");
    soft_force_a: assert property (sfr_wr && sfr_addr == 8'hef && sfr_wdata[4] && !sys_reset_q
        |=> sys_reset_q)
        else $error("soft reset not forced");
    monitor_read_a: assert property (sfr_rd && sfr_addr == 8'hff |=> sfr_rdata_q ==
        {$past(supply_monitor_on_q), $past(supply_above_threshold), 6'h00})
        else $error("monitor control read wrong");
    cause_top_a: assert property (sfr_rd && sfr_addr == 8'hef |=> !sfr_rdata_q[7])
        else $error("cause bit 7 set");
    dog_on_a: assert property ($fell(sys_reset_q) |-> watchdog_enable_q)
        else $error("watchdog off after reset");
    dog_tick_gap_a: assert property (watchdog_tick_q |=> !watchdog_tick_q [*8])
        else $error("watchdog tick too fast");
    monitor_kept_a: assert property ($fell(supply_monitor_on_q)
        |-> $past(sfr_wr) && $past(sfr_addr) == 8'hff)
        else $error("monitor enable lost");
    reset_hold_a: assert property ($rose(sys_reset_q) |=> sys_reset_q [*8])
        else $error("reset too short");
    soft_c: cover property (sfr_wr && sfr_addr == 8'hef && sfr_wdata[4] && !sys_reset_q);
    pin_c: cover property (rst_pin_oe && !rst_pin_i);
    tick_c: cover property (watchdog_tick_q);
endmodule
bind rsc_reset_source_controller rsc_monitor u_mon (
    .clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q, .rst_pin_i,
    .rst_pin_o, .rst_pin_oe, .supply_above_threshold, .sys_reset_q, .supply_monitor_on_q,
    .watchdog_enable_q, .watchdog_tick_q
);

// [rsc_pin_partner.sv]
// External reset circuitry on the pulled-up reset line
`timescale 1ns/1ps
module rsc_pin_partner (
    input  wire logic ext_req,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output logic      pin_level
);
    // Pull-up wins when nobody pulls low, so a released line never floats
    assign pin_level = !(ext_req || (dev_oe && !dev_o));
endmodule

// [rsc_reset_source_controller_bench.sv]
// Self-checking bench of the reset source controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
$display("Error %s expected %h seen %h", nm, ex, got); end end
module rsc_reset_source_controller_bench;
    import rsc_pkg::*;
    logic        clk, rstn, sfr_wr, sfr_rd, sfr_rmw, rst_pin_i, rst_pin_o, rst_pin_oe;
    logic        supply_above_threshold, clk_alive_tick, comparator_out, watchdog_timeout;
    logic        watchdog_disable, part_16k, program_store_write_enable, flash_wr_strobe;
    logic        code_rd_strobe, fetch_strobe, flash_sec_violation, sys_reset_q, ext_req;
    logic        supply_monitor_on_q, watchdog_enable_q, watchdog_tick_q;
    logic [7:0]  sfr_addr, sfr_wdata;
    logic [15:0] flash_wr_addr, code_rd_addr, fetch_addr;
    rsc_byte_t   sfr_rdata_q, got;
    int          err_total, checks_done, seed, i, lim, bad, exp_cause;
    int          exp_q[$];
    // Short clock-loss count keeps the run brief
    rsc_reset_source_controller #(.CLK_LOSS_CYC(20)) u_dut (
        .clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rmw, .sfr_wdata, .sfr_rdata_q,
        .rst_pin_i, .rst_pin_o, .rst_pin_oe, .supply_above_threshold, .clk_alive_tick,
        .comparator_out, .watchdog_timeout, .watchdog_disable, .part_16k,
        .program_store_write_enable, .flash_wr_strobe, .flash_wr_addr, .code_rd_strobe,
        .code_rd_addr, .fetch_strobe, .fetch_addr, .flash_sec_violation, .sys_reset_q,
        .supply_monitor_on_q, .watchdog_enable_q, .watchdog_tick_q
    );
    rsc_pin_partner u_pin (
        .ext_req, .dev_o(rst_pin_o), .dev_oe(rst_pin_oe), .pin_level(rst_pin_i)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic m);
        @(negedge clk);
        {sfr_addr, sfr_rd, sfr_rmw} = {a, 1'b1, m};
        @(negedge clk);
        {sfr_rd, sfr_rmw} = 2'h0;
        got = sfr_rdata_q;
    endtask
    task automatic wait_for(input logic lvl, input int n);
        int k;
        k = 0;
        while (sys_reset_q !== lvl && k < n) begin
            @(negedge clk);
            k++;
        end
        if (sys_reset_q !== lvl) begin
            err_total++;
            $display("Error sys_reset_q expected %h seen %h", lvl, sys_reset_q);
            results();
        end
    endtask
    // One strobe per source code: 3 watchdog, 6 write, 7 read, 8 fetch, 9 security
    task automatic hit(input int k, input int a);
        @(negedge clk);
        {flash_wr_addr, code_rd_addr, fetch_addr} = {3{16'(a)}};
        {flash_wr_strobe, code_rd_strobe, fetch_strobe} = {k == 6, k == 7, k == 8};
        {flash_sec_violation, watchdog_timeout} = {k == 9, k == 3};
        @(negedge clk);
        {flash_wr_strobe, code_rd_strobe, fetch_strobe, flash_sec_violation} = 4'h0;
        watchdog_timeout = 1'b0;
    endtask
    initial begin
        seed = 48;
        {sfr_wr, sfr_rd, sfr_rmw, ext_req, watchdog_timeout, watchdog_disable, rstn} = '0;
        {flash_wr_strobe, code_rd_strobe, fetch_strobe, flash_sec_violation} = '0;
        {sfr_addr, sfr_wdata, flash_wr_addr, code_rd_addr, fetch_addr} = '0;
        {supply_above_threshold, clk_alive_tick, comparator_out} = 3'h7;
        program_store_write_enable = 1'b1;
        part_16k = 1'($random(seed));
        lim = part_16k ? 16'h3dff : 16'h1fff;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        wait_for(1'b0, 1200);
        rd(8'hef, 1'b0);
        `CHK("cause", 8'h02, got)
        wr(8'hff, 8'h3f);
        rd(8'hff, 1'b0);
        `CHK("monitor", 8'h40, got)
        supply_above_threshold = 1'b0;
        rd(8'hff, 1'b0);
        `CHK("monitor", 8'h00, got)
        supply_above_threshold = 1'b1;
        wr(8'hff, 8'h80);
        rd(8'hff, 1'b0);
        `CHK("monitor", 8'hc0, got)
        wr(8'hef, 8'h24);
        rd(8'hef, 1'b1);
        `CHK("rmw", 8'h24, got)
        rd(8'hef, 1'b0);
        `CHK("cause", 8'h02, got)
        wr(8'hef, 8'h80);
        rd(8'hef, 1'b1);
        `CHK("rmw", 8'h00, got)
        $display("Test registers done");
        for (i = 0; i < 10; i++) begin
            bad = lim + 1 + ($random(seed) & 255);
            case (i)
                0: ext_req = 1'b1;
                1: begin
                    wr(8'hef, 8'h02);
                    supply_above_threshold = 1'b0;
                end
                2: begin
                    wr(8'hef, 8'h04);
                    clk_alive_tick = 1'b0;
                end
                4: wr(8'hef, 8'h10);
                5: begin
                    comparator_out = 1'b0;
                    wr(8'hef, 8'h20);
                end
                6, 7, 8: begin
                    program_store_write_enable = (i != 6);
                    hit(i, (i == 6) ? bad : lim);
                    `CHK("sys_reset_q", 1'b0, sys_reset_q)
                    program_store_write_enable = 1'b1;
                    hit(i, bad);
                end
                default: hit(i, 0);
            endcase
            exp_q.push_back(1 << ((i > 6) ? 6 : i));
            wait_for(1'b1, 40);
            @(negedge clk);
            `CHK("rst_pin_oe", (i == 1), rst_pin_oe)
            ext_req = 1'b0;
            {supply_above_threshold, clk_alive_tick, comparator_out} = 3'h7;
            wait_for(1'b0, 1200);
            `CHK("watchdog_enable_q", 1'b1, watchdog_enable_q)
            exp_cause = exp_q.pop_front();
            rd(8'hef, 1'b0);
            `CHK("cause", 8'(exp_cause), got)
            $display("Test source %0d done", i);
        end
        watchdog_disable = 1'b1;
        @(negedge clk);
        watchdog_disable = 1'b0;
        `CHK("watchdog_enable_q", 1'b0, watchdog_enable_q)
        rd(8'hff, 1'b0);
        `CHK("monitor", 8'hc0, got)
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        wait_for(1'b0, 1200);
        bad = 0;
        while (!watchdog_tick_q && bad < 30) begin
            @(negedge clk);
            bad++;
        end
        lim = 0;
        do begin
            @(negedge clk);
            lim++;
        end while (!watchdog_tick_q && lim < 30);
        `CHK("tick_gap", 12, lim)
        rd(8'hff, 1'b0);
        `CHK("monitor", 8'h40, got)
        $display("Test final done");
        results();
    end
endmodule
